//--- sram_pkg.sv
// constants and types shared by both ends of the pipelined burst sram link
// assumes a single clock shared by controller and memory
package sram_pkg;
  localparam int ADDR_W     = 19;  // word address width
  localparam int LANES      = 4;   // byte lanes
  localparam int LANE_W     = 9;   // 8 data bits + 1 parity bit (parity on top)
  localparam int WORD_W     = 36;  // LANES * LANE_W
  localparam int BURST_W    = 2;   // low address bits sequenced by the burst counter
  localparam int PIPE_DEPTH = 2;   // enabled edges from address cycle to data

  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic [LANES-1:0]   LANES_OFF_N = 4'hF;

  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} op_t;
  typedef enum logic [1:0] {BURST_NONE, BURST_READ, BURST_WRITE} burst_t;

  // low address bits of a burst beat: interleaved xor or linear increment
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                  input logic [BURST_W-1:0] count,
                                                  input logic               linear);
    burst_low = linear ? BURST_W'(start + count) : (start ^ count);
  endfunction : burst_low
endpackage : sram_pkg

//--- sram_bus_if.sv
// synchronous sram bus between a memory controller and the burst sram
// the shared data wire is resolved here from the two drivers' enables
`timescale 1ns/10ps
`default_nettype none
interface sram_bus_if;
  import sram_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              chip_select1_n;
  logic              chip_enable_high;
  logic              chip_select3_n;
  logic              burst_step_or_load;  // low = load address, high = advance
  logic              read_write_sel;      // high = read, low = write
  logic [LANES-1:0]  any_byte_write_n;    // byte0_write_n .. byte3_write_n
  logic              output_enable_n;
  logic              clock_gate_n;        // high = ignore clock edge
  logic              snooze_input;
  logic              burst_order_select;  // high = interleaved, low = linear
  logic [WORD_W-1:0] dq_ctl_out;
  logic              dq_ctl_oe_n;
  logic [WORD_W-1:0] dq_mem_out;
  logic              dq_mem_oe_n;
  logic [WORD_W-1:0] dq;

  // undriven bus reads as zero; contention resolves to the memory's value
  assign dq = !dq_mem_oe_n ? dq_mem_out : (!dq_ctl_oe_n ? dq_ctl_out : '0);

  modport ctl (output addr, chip_select1_n, chip_enable_high, chip_select3_n,
               burst_step_or_load, read_write_sel, any_byte_write_n, output_enable_n,
               clock_gate_n, snooze_input, burst_order_select, dq_ctl_out, dq_ctl_oe_n,
               input dq);
  modport mem (input addr, chip_select1_n, chip_enable_high, chip_select3_n,
               burst_step_or_load, read_write_sel, any_byte_write_n, output_enable_n,
               clock_gate_n, snooze_input, burst_order_select, dq,
               output dq_mem_out, dq_mem_oe_n);
endinterface : sram_bus_if
`default_nettype wire

//--- burst_sram_mem.sv
// memory end: cycle decode, burst counter, two-stage pipeline and array
// assumes all pins synchronous to clk except output enable and snooze
`timescale 1ns/10ps
`default_nettype none
module burst_sram_mem
  import sram_pkg::*;
#(
  parameter int DEPTH_LOG2 = sram_pkg::ADDR_W  // array depth as address bits
)(
  input  wire logic clk,                     // memory clock
  input  wire logic arst_n,                  // asynchronous reset, active low
  sram_bus_if.mem   bus,                     // pins facing the controller
  output logic      in_snooze,               // snooze level seen by the core
  output logic      burst_active             // a selected burst is in progress
);
  import sram_pkg::*;

  if (DEPTH_LOG2 < BURST_W || DEPTH_LOG2 > ADDR_W)
  begin : g_bad_depth
    $error("burst_sram_mem: DEPTH_LOG2 out of range");
  end
  if (LANES * LANE_W != WORD_W)
  begin : g_bad_lanes
    $error("burst_sram_mem: lane layout does not fill the word");
  end

  logic [WORD_W-1:0]     array_q [0:(2**DEPTH_LOG2)-1];

  burst_t                burst;
  logic [ADDR_W-1:0]     base_addr;
  logic [BURST_W-1:0]    beat;
  op_t                   s1_op;
  logic [ADDR_W-1:0]     s1_addr;
  logic [LANES-1:0]      s1_lane_n;
  op_t                   s2_op;
  logic [ADDR_W-1:0]     s2_addr;
  logic [LANES-1:0]      s2_lane_n;
  logic [WORD_W-1:0]     read_word;
  logic [WORD_W-1:0]     read_fwd;
  logic                  read_valid;

  logic                  edge_en;
  logic                  is_load;
  logic                  selected;
  logic                  lanes_on;
  logic [BURST_W-1:0]    next_beat;
  logic [ADDR_W-1:0]     beat_addr;
  op_t                   next_op;

  // snooze and the clock gate both freeze every register of the core
  assign edge_en   = !bus.clock_gate_n && !bus.snooze_input;
  assign is_load   = !bus.burst_step_or_load;
  assign selected  = !bus.chip_select1_n && bus.chip_enable_high
                     && !bus.chip_select3_n;
  assign lanes_on  = (bus.any_byte_write_n != LANES_OFF_N);
  assign next_beat = BURST_W'(beat + BURST_STEP);
  assign in_snooze = bus.snooze_input;
  assign burst_active = (burst != BURST_NONE);

  // address of the beat this advance cycle addresses
  always_comb
  begin
    beat_addr = base_addr;
    beat_addr[BURST_W-1:0] = burst_low(base_addr[BURST_W-1:0], next_beat,
                                       !bus.burst_order_select);
  end

  // operation put into the pipeline by this address cycle
  always_comb
  begin
    next_op = OP_NONE;
    if (is_load)
    begin
      if (selected)
      begin
        if (bus.read_write_sel)
          next_op = OP_READ;
        else if (lanes_on)
          next_op = OP_WRITE;
      end
    end
    else
    begin
      case (burst)
        BURST_READ:  next_op = OP_READ;
        BURST_WRITE: next_op = lanes_on ? OP_WRITE : OP_NONE;
        BURST_NONE:  next_op = OP_NONE;
        default:     next_op = OP_NONE;
      endcase
    end
  end

  // burst direction and counter; a write abort load still opens a write burst
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      burst     <= BURST_NONE;
      base_addr <= '0;
      beat      <= BURST_FIRST;
    end
    else if (edge_en)
    begin
      if (is_load)
      begin
        base_addr <= bus.addr;
        beat      <= BURST_FIRST;
        if (!selected)
          burst <= BURST_NONE;
        else if (bus.read_write_sel)
          burst <= BURST_READ;
        else
          burst <= BURST_WRITE;
      end
      else if (burst != BURST_NONE)
        beat <= next_beat;
    end
  end

  // stage one: address cycle captured with its byte enables
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_op     <= OP_NONE;
      s1_addr   <= '0;
      s1_lane_n <= LANES_OFF_N;
    end
    else if (edge_en)
    begin
      s1_op     <= next_op;
      s1_addr   <= is_load ? bus.addr : beat_addr;
      s1_lane_n <= bus.any_byte_write_n;
    end
  end

  // stage two: one more enabled edge before the data cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s2_op     <= OP_NONE;
      s2_addr   <= '0;
      s2_lane_n <= LANES_OFF_N;
    end
    else if (edge_en)
    begin
      s2_op     <= s1_op;
      s2_addr   <= s1_addr;
      s2_lane_n <= s1_lane_n;
    end
  end

  // write lanes sampled at the second enabled edge after their address
  always_ff @(posedge clk)
  begin
    if (edge_en && s2_op == OP_WRITE)
    begin
      for (int lane = 0; lane < LANES; lane++)
      begin
        if (!s2_lane_n[lane])
          array_q[s2_addr[DEPTH_LOG2-1:0]][lane*LANE_W +: LANE_W]
            <= bus.dq[lane*LANE_W +: LANE_W];
      end
    end
  end

  // a read right behind a write to the same word sees the lanes stored this edge
  always_comb
  begin
    read_fwd = array_q[s1_addr[DEPTH_LOG2-1:0]];
    for (int lane = 0; lane < LANES; lane++)
    begin
      if (s2_op == OP_WRITE && !s2_lane_n[lane]
          && s2_addr[DEPTH_LOG2-1:0] == s1_addr[DEPTH_LOG2-1:0])
        read_fwd[lane*LANE_W +: LANE_W] = bus.dq[lane*LANE_W +: LANE_W];
    end
  end

  // read word driven in the same bus cycle a write would use, so no turnaround gap
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      read_word  <= '0;
      read_valid <= 1'b0;
    end
    else if (edge_en)
    begin
      read_valid <= (s1_op == OP_READ);
      if (s1_op == OP_READ)
        read_word <= read_fwd;
    end
  end

  // a stalled edge leaves read_valid as it was, so idle outputs stay off
  assign bus.dq_mem_out  = read_word;
  assign bus.dq_mem_oe_n = !(read_valid && !bus.output_enable_n
                             && !bus.snooze_input);
endmodule : burst_sram_mem
`default_nettype wire

//--- burst_sram_ctl.sv
// controller end: turns user requests into pin cycles and tracks the data pipe
// assumes the memory samples the pins on the same clk edge
`timescale 1ns/10ps
`default_nettype none
module burst_sram_ctl
  import sram_pkg::*;
(
  input  wire logic              clk,          // controller clock
  input  wire logic              arst_n,       // asynchronous reset, active low
  sram_bus_if.ctl                bus,          // pins facing the memory
  input  wire logic              req_valid,    // request present
  output logic                   req_ready,    // request taken this edge
  input  wire logic              req_load,     // 1 = load address, 0 = advance
  input  wire logic              req_write,    // load only: 1 = write burst
  input  wire logic [ADDR_W-1:0] req_addr,     // load address
  input  wire logic [LANES-1:0]  req_lane_n,   // byte write enables, active low
  input  wire logic [WORD_W-1:0] req_wdata,    // write data for this beat
  input  wire logic              stall,        // hold the memory clock
  input  wire logic              snooze,       // put the memory to sleep
  input  wire logic              linear_order, // 1 = linear burst order
  input  wire logic              read_oe_n,    // output enable to the memory
  output logic [WORD_W-1:0]      rdata,        // read word
  output logic                   rdata_valid   // one-cycle read strobe
);
  import sram_pkg::*;

  burst_t            burst;
  op_t               pin_op;
  logic [WORD_W-1:0] pin_wdata;
  op_t               h1_op;
  logic [WORD_W-1:0] h1_wdata;
  op_t               h2_op;
  logic [WORD_W-1:0] h2_wdata;
  logic              h3_read;
  logic              edge_en;
  logic              lanes_on;
  op_t               next_op;

  assign edge_en   = !bus.clock_gate_n && !bus.snooze_input;
  assign req_ready = edge_en;
  assign lanes_on  = (req_lane_n != LANES_OFF_N);

  always_comb
  begin
    next_op = OP_NONE;
    if (req_valid)
    begin
      if (req_load)
        next_op = req_write ? (lanes_on ? OP_WRITE : OP_NONE) : OP_READ;
      else if (burst == BURST_WRITE)
        next_op = lanes_on ? OP_WRITE : OP_NONE;
      else if (burst == BURST_READ)
        next_op = OP_READ;
    end
  end

  // level pins follow the user every edge; cycle pins only on enabled edges
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus.clock_gate_n       <= 1'b0;
      bus.snooze_input       <= 1'b0;
      bus.burst_order_select <= 1'b1;
      bus.output_enable_n    <= 1'b1;
    end
    else
    begin
      bus.clock_gate_n       <= stall;
      bus.snooze_input       <= snooze;
      bus.burst_order_select <= !linear_order;
      bus.output_enable_n    <= read_oe_n;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus.addr               <= '0;
      bus.chip_select1_n     <= 1'b1;
      bus.chip_enable_high   <= 1'b0;
      bus.chip_select3_n     <= 1'b1;
      bus.burst_step_or_load <= 1'b0;
      bus.read_write_sel     <= 1'b1;
      bus.any_byte_write_n   <= LANES_OFF_N;
      burst                  <= BURST_NONE;
      pin_op                 <= OP_NONE;
      pin_wdata              <= '0;
    end
    else if (edge_en)
    begin
      pin_op    <= next_op;
      pin_wdata <= req_wdata;
      bus.any_byte_write_n <= req_valid ? req_lane_n : LANES_OFF_N;
      if (!req_valid || req_load)
      begin
        // idle edges become deselect loads
        bus.burst_step_or_load <= 1'b0;
        bus.chip_select1_n     <= !req_valid;
        bus.chip_enable_high   <= req_valid;
        bus.chip_select3_n     <= !req_valid;
        bus.read_write_sel     <= !req_write;
        bus.addr               <= req_addr;
        burst <= !req_valid ? BURST_NONE : (req_write ? BURST_WRITE : BURST_READ);
      end
      else
        bus.burst_step_or_load <= 1'b1;
    end
  end

  // data pipe aligned to the memory's enabled edges
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      h1_op       <= OP_NONE;
      h1_wdata    <= '0;
      h2_op       <= OP_NONE;
      h2_wdata    <= '0;
      h3_read     <= 1'b0;
      rdata       <= '0;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= 1'b0;
      if (edge_en)
      begin
        h1_op    <= pin_op;
        h1_wdata <= pin_wdata;
        h2_op    <= h1_op;
        h2_wdata <= h1_wdata;
        h3_read  <= (h1_op == OP_READ);
        if (h3_read)
        begin
          rdata       <= bus.dq;
          rdata_valid <= 1'b1;
        end
      end
    end
  end

  assign bus.dq_ctl_out  = h2_wdata;
  assign bus.dq_ctl_oe_n = !(h2_op == OP_WRITE);
endmodule : burst_sram_ctl
`default_nettype wire

//--- sram_link_chk.sv
// pin checker for the sram link between controller and memory
// assumes the bus signals, clock and reset are wired in by name beside the interface
`timescale 1ns/10ps
`default_nettype none
module sram_link_chk
  import sram_pkg::*;
(
  input wire logic                        clk,                // clock
  input wire logic                        arst_n,             // reset
  input wire logic                        chip_select1_n,     // select
  input wire logic                        chip_enable_high,   // select
  input wire logic                        chip_select3_n,     // select
  input wire logic                        burst_step_or_load, // 0 load
  input wire logic                        read_write_sel,     // 1 read
  input wire logic [sram_pkg::LANES-1:0]  any_byte_write_n,   // lanes
  input wire logic                        output_enable_n,    // oe
  input wire logic                        clock_gate_n,       // stall
  input wire logic                        snooze_input,       // sleep
  input wire logic                        dq_ctl_oe_n,        // ctl drive
  input wire logic                        dq_mem_oe_n,        // mem drive
  input wire logic [sram_pkg::WORD_W-1:0] dq_mem_out          // mem data
);
  logic en;
  logic sel;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // an edge counts only when neither stalled nor asleep
  assign en  = !clock_gate_n && !snooze_input;
  assign sel = !chip_select1_n && chip_enable_high && !chip_select3_n;

  property p_snooze_quiet;
    snooze_input |-> dq_mem_oe_n;
  endproperty
  a_snooze_quiet: assert property (p_snooze_quiet)
    else $error("memory drives bus in snooze");
  property p_oe_quiet;
    output_enable_n |-> dq_mem_oe_n;
  endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("memory drives bus with output enable off");
  property p_read_drive;
    (en && !burst_step_or_load && sel && read_write_sel) ##1 en
      |=> (output_enable_n || snooze_input || !dq_mem_oe_n);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data not driven two edges after address");
  property p_nonread_quiet;
    (en && !burst_step_or_load && !(sel && read_write_sel)) ##1 en |=> dq_mem_oe_n;
  endproperty
  a_nonread_quiet: assert property (p_nonread_quiet)
    else $error("memory drives bus after a load that is no read");
  property p_write_drive;
    (en && !burst_step_or_load && sel && !read_write_sel && any_byte_write_n != LANES_OFF_N)
      ##1 en ##1 en |-> !dq_ctl_oe_n;
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("write data missing two edges after address");
  property p_stall_hold;
    clock_gate_n |=> $stable(dq_mem_out);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("memory output moved on an ignored edge");
  property p_stall_quiet;
    (clock_gate_n && dq_mem_oe_n && !output_enable_n && !snooze_input) |=> dq_mem_oe_n;
  endproperty
  a_stall_quiet: assert property (p_stall_quiet)
    else $error("memory began driving during a stall");
  property p_snooze_hold;
    snooze_input |=> $stable(dq_mem_out);
  endproperty
  a_snooze_hold: assert property (p_snooze_hold)
    else $error("memory output moved in snooze");
endmodule : sram_link_chk
`default_nettype wire

//--- pipelined_burst_sram_control_test.sv
// testbench: controller and memory joined by the bus, driven from the user port
// assumes the hand-over timing; read words are checked against a local array model
`timescale 1ns/10ps
`default_nettype none
module pipelined_burst_sram_control_test;
  import sram_pkg::*;
  logic              clk = 1'h0;
  logic              arst_n = 1'h0;
  logic              req_valid = 1'h0;
  logic              req_ready;
  logic              req_load = 1'h0;
  logic              req_write = 1'h0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [LANES-1:0]  req_lane_n = 4'hF;
  logic [WORD_W-1:0] req_wdata = '0;
  logic              stall = 1'h0;
  logic              snooze = 1'h0;
  logic              linear_order = 1'h0;
  logic              read_oe_n = 1'h0;
  logic [WORD_W-1:0] rdata;
  logic              rdata_valid;
  logic              in_snooze;
  logic              burst_active;
  logic [ADDR_W-1:0] base;
  int                num_errors = 0;
  int                n_compared = 0;
  int                cycles = 0;
  logic [WORD_W-1:0] model[logic [ADDR_W-1:0]];
  logic [WORD_W-1:0] got_q[$];
  logic [WORD_W-1:0] exp_q[$];

  sram_bus_if bus ();
  burst_sram_mem #(.DEPTH_LOG2(8)) i_burst_sram_mem (.clk(clk), .arst_n(arst_n), .bus(bus),
    .in_snooze(in_snooze), .burst_active(burst_active));
  burst_sram_ctl i_burst_sram_ctl (.clk(clk), .arst_n(arst_n), .bus(bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_load(req_load), .req_write(req_write), .req_addr(req_addr),
    .req_lane_n(req_lane_n), .req_wdata(req_wdata), .stall(stall), .snooze(snooze),
    .linear_order(linear_order), .read_oe_n(read_oe_n), .rdata(rdata), .rdata_valid(rdata_valid));
  sram_link_chk i_sram_link_chk (.clk(clk), .arst_n(arst_n), .chip_select1_n(bus.chip_select1_n),
    .chip_enable_high(bus.chip_enable_high), .chip_select3_n(bus.chip_select3_n),
    .burst_step_or_load(bus.burst_step_or_load), .read_write_sel(bus.read_write_sel),
    .any_byte_write_n(bus.any_byte_write_n), .output_enable_n(bus.output_enable_n),
    .clock_gate_n(bus.clock_gate_n), .snooze_input(bus.snooze_input),
    .dq_ctl_oe_n(bus.dq_ctl_oe_n), .dq_mem_oe_n(bus.dq_mem_oe_n), .dq_mem_out(bus.dq_mem_out));

  always #12.5 clk = ~clk;

  // the read strobe lasts one cycle, so the falling edge sees it exactly once
  always @(negedge clk)
    if (rdata_valid === 1'h1)
      got_q.push_back(rdata);

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic check(input string what, input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] want);
    n_compared++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] a, input int k);
    beat_addr = {a[ADDR_W-1:2], linear_order ? 2'(a[1:0] + 2'(k)) : a[1:0] ^ 2'(k)};
  endfunction : beat_addr

  // request stays up until taken; a stalled beat keeps it held, never dropped
  task automatic beat(input logic ld, input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] ln, input logic [WORD_W-1:0] d, input logic st);
    int n;
    @(negedge clk);
    req_valid = 1'h1;
    req_load = ld;
    req_write = wr;
    req_addr = a;
    req_lane_n = ln;
    req_wdata = d;
    stall = st;
    n = 0;
    while (req_ready !== 1'h1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask : beat

  task automatic idle(input int k);
    @(negedge clk);
    req_valid = 1'h0;
    repeat (k) @(posedge clk);
  endtask : idle

  task automatic wburst(input logic [ADDR_W-1:0] a, input logic [15:0] lanes,
                        input logic [WORD_W-1:0] d);
    logic [ADDR_W-1:0] ad;
    logic [WORD_W-1:0] w;
    for (int k = 0; k < 4; k++)
    begin
      ad = beat_addr(a, k);
      w = d + WORD_W'(k);
      beat(k == 0, 1'h1, a, lanes[4*k+:4], w, 1'h0);
      for (int i = 0; i < LANES; i++)
        if (!lanes[4*k+i])
          model[ad][LANE_W*i+:LANE_W] = w[LANE_W*i+:LANE_W];
    end
  endtask : wburst

  task automatic rburst(input logic [ADDR_W-1:0] a, input int n, input logic p);
    for (int k = 0; k < n; k++)
    begin
      beat(k == 0, 1'h0, a, 4'hF, '0, p && k == 1);
      if (read_oe_n === 1'h0)
        exp_q.push_back(model[beat_addr(a, k)]);
      if (p && k == 1)
      begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        check("burst held in stall", WORD_W'(burst_active), 36'h1);
        check("no read in stall", WORD_W'(got_q.size()), 36'h0);
      end
    end
  endtask : rburst

  task automatic flush();
    idle(10);
    @(negedge clk);
    check("read count", WORD_W'(got_q.size()), WORD_W'(exp_q.size()));
    check("bus released", WORD_W'(bus.dq_mem_oe_n), 36'h1);
    while (got_q.size() > 0 && exp_q.size() > 0)
      check("read word", got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask : flush

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'h1;
    idle(2);
    // both orders, every start offset; full fill first so partial lanes read back known
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 4; s++)
      begin
        @(negedge clk);
        linear_order = o[0];
        base = ADDR_W'(32 * o + 9 * s);
        wburst(base, 16'h0000, 36'h123456789 ^ WORD_W'(base));
        wburst(base, 16'hF5E0, 36'hFEDCBA987 ^ WORD_W'(base));
        rburst(base, 5, s == 2);
        flush();
      end
    check("no burst when idle", WORD_W'(burst_active), 36'h0);
    beat(1'h0, 1'h0, base, 4'hF, '0, 1'h0);
    flush();
    // read then write with no idle cycle, then read the last written word at once
    rburst(base, 1, 1'h0);
    wburst(base, 16'h0000, 36'h0A5A5A5A5);
    rburst(beat_addr(base, 3), 4, 1'h0);
    flush();
    @(negedge clk);
    read_oe_n = 1'h1;
    rburst(base, 4, 1'h0);
    idle(10);
    @(negedge clk);
    check("dummy read count", WORD_W'(got_q.size()), 36'h4);
    while (got_q.size() > 0)
      check("dummy read data", got_q.pop_front(), 36'h0);
    read_oe_n = 1'h0;
    stall = 1'h1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    stall = 1'h0;
    // sleep while a read word is ready to drive: the bus must stay released
    beat(1'h1, 1'h0, base, 4'hF, '0, 1'h0);
    exp_q.push_back(model[base]);
    idle(1);
    @(negedge clk);
    snooze = 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("ready in snooze", WORD_W'(req_ready), 36'h0);
    check("snooze level", WORD_W'(in_snooze), 36'h1);
    check("bus off in snooze", WORD_W'(bus.dq_mem_oe_n), 36'h1);
    check("no read in snooze", WORD_W'(got_q.size()), 36'h0);
    snooze = 1'h0;
    idle(4);
    rburst(base, 4, 1'h0);
    flush();
    results();
  end
endmodule : pipelined_burst_sram_control_test
`default_nettype wire
